/* wsd_defs.svh */
// Purpose: Register indices, field positions, reset values and widths of the
//          waveform shutdown and dead-band block.
// Assumes: A register sits at byte address 4 * index on the AXI4-Lite bus.
// Notes:   Definitions only.
// Operation
// RULE1: The shutdown status bit reads 1 while a shutdown is in force and 0 when none has occurred.
// RULE2: The restart enable bit at 1 allows automatic restart, at 0 software must restart.
// RULE3: In shutdown, outputs B and D take their 2-bit safe code: high, low, tri-state or inactive.
// RULE4: In shutdown, outputs A and C take their own 2-bit safe code with the same meanings.
// RULE5: Software may set the status bit while disabled, forcing the outputs to their safe states.
// RULE6: After the status clears, outputs stay safe until the next rising edge of the data input.
// RULE7: Six source enable bits decide which sources may trigger a shutdown.
// RULE8: Comparator sources on enables 5 and 4 request shutdown while their output is low.
// RULE9: Timer sources on enables 3, 2 and 1 request shutdown while their postscaled output is high.
// RULE10: Source 0 is the shutdown input pin, which requests shutdown while low.
// RULE11: After a rising data edge the dead band lasts n to n+1 clocks, n being the rising count.
// RULE12: After a falling data edge the dead band lasts n to n+1 clocks, n being the falling count.
// RULE13: A dead-band count of zero bypasses dead-band generation for that edge.
// RULE14: Both dead-band counts are undefined at power-on and keep their value over other resets.
// RULE15: With restart enabled, hardware clears the status bit once the shutdown condition ends.
// RULE16: A clock source bit selects system clock at 0 or the internal oscillator at 1.
// RULE17: Hardware sets the status bit whenever any enabled source is at its active level.
`ifndef WSD_DEFS_SVH
`define WSD_DEFS_SVH

`define WSD_ADDR_W 16
`define WSD_DATA_W 32
`define WSD_DB_W 6
`define WSD_SRC_W 6

`define WSD_IDX_RISE_DB 14'h0f42
`define WSD_IDX_FALL_DB 14'h0f43
`define WSD_IDX_GEN_CTRL 14'h0f44
`define WSD_IDX_POLARITY 14'h0f45
`define WSD_IDX_SHUT_CTRL 14'h0f46
`define WSD_IDX_SRC_EN 14'h0f47
`define WSD_IDX_IRQ_STATUS 14'h0f4a
`define WSD_IDX_IRQ_MASK 14'h0f4b

`define WSD_BIT_SHUTDOWN 7
`define WSD_BIT_REN 6
`define WSD_BIT_ENABLE 7
`define WSD_BIT_CLK_SRC 0
`define WSD_BIT_DATA_IN 5
`define WSD_IRQ_SHUT_ENTER 0
`define WSD_IRQ_AUTO_RESTART 1
`define WSD_IRQ_W 2

`define WSD_SAFE_RST 2'h1
`define WSD_SRC_EN_RST 6'h00
`define WSD_POL_RST 4'h0

`define WSD_RESP_OKAY 2'h0
`define WSD_RESP_SLVERR 2'h2

`endif

/* wsd_pkg.sv */
// Purpose: Types shared by the waveform shutdown and dead-band block.
// Assumes: Nothing beyond the constants header.
// Notes:   The hold states are Gray coded along run, shut, rearm.
package wsd_pkg;

	typedef enum logic [1:0] {
		WSD_RUN = 2'h0,
		WSD_SHUT = 2'h1,
		WSD_REARM = 2'h3
	} wsd_hold_e;

	typedef enum logic [1:0] {
		WSD_SAFE_INACTIVE = 2'h0,
		WSD_SAFE_TRI = 2'h1,
		WSD_SAFE_LOW = 2'h2,
		WSD_SAFE_HIGH = 2'h3
	} wsd_safe_e;

endpackage

/* wsd_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter and edge pulses.
// Assumes: Inputs are asynchronous to clk.
// Notes:   A bit changes only when the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module wsd_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q,
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);
	import wsd_pkg::*;

	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1 <= INIT;
			s2 <= INIT;
			s3 <= INIT;
			q <= INIT;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			q <= ((s2 ~^ s3) & s3) | ((s2 ^ s3) & q);
		end
	end

	assign rise = ~q & s2 & s3;
	assign fall = q & ~s2 & ~s3;
endmodule
`default_nettype wire

/* wsd_deadband.sv */
// Purpose: One dead-band timer, restarted by a data edge.
// Assumes: trig is a one-cycle pulse on the data edge.
// Notes:   The trigger is already a few cycles behind the pin, so the band
//          lands between n and n+1 clocks of the synchronised edge.
`timescale 1ns/1ps
`default_nettype none
module wsd_deadband #(
	parameter int CW = 6
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic trig,
	input wire logic [CW-1:0] count,
	output logic active
);
	import wsd_pkg::*;

	logic [CW-1:0] remain;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			remain <= '0;
		end else if (trig) begin
			remain <= count;
		end else if (remain != '0) begin
			remain <= remain - 1'b1;
		end
	end

	// A zero count loads zero, so the band never opens.
	assign active = (remain != '0); // RULE13
endmodule
`default_nettype wire

/* wsd_top.sv */
// Purpose: Auto-shutdown, restart and dead-band core of a complementary
//          waveform generator, with an AXI4-Lite register port.
// Assumes: CLK is the selected generator clock at 50 MHz; all pin inputs
//          are asynchronous and pass the three-stage synchroniser.
// Notes:   Outputs A and C carry the rising-delayed phase, B and D the
//          falling-delayed complement.
`timescale 1ns/1ps
`default_nettype none
`include "wsd_defs.svh"
module wsd_top (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic [`WSD_ADDR_W-1:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [`WSD_DATA_W-1:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [`WSD_ADDR_W-1:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [`WSD_DATA_W-1:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	input wire logic DATA_IN,
	input wire logic COMPARATOR_TWO_OUTPUT,
	input wire logic COMPARATOR_ONE_OUTPUT,
	input wire logic TIMER_SIX_POSTSCALED,
	input wire logic TIMER_FOUR_POSTSCALED,
	input wire logic TIMER_TWO_POSTSCALED,
	input wire logic SHUTDOWN_PIN,
	output logic OUT_A,
	output logic OUT_A_OE,
	output logic OUT_B,
	output logic OUT_B_OE,
	output logic OUT_C,
	output logic OUT_C_OE,
	output logic OUT_D,
	output logic OUT_D_OE,
	output logic GEN_CLK_SEL,
	output logic IRQ
);
	import wsd_pkg::*;

	localparam int NPIN = 7;
	localparam logic [NPIN-1:0] PIN_INIT = 7'h31;

	logic aw_held;
	logic [`WSD_ADDR_W-1:0] aw_addr;
	logic w_held;
	logic [`WSD_DATA_W-1:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire;
	logic wr_lane0;
	logic [NPIN-1:0] pin_q;
	logic [NPIN-1:0] pin_rise;
	logic [NPIN-1:0] pin_fall;
	logic data_lvl;
	logic data_rise;
	logic data_fall;
	logic [`WSD_SRC_W-1:0] src_active;
	logic shut_req;
	logic [`WSD_DB_W-1:0] rise_deadband_count;
	logic [`WSD_DB_W-1:0] fall_deadband_count;
	logic [`WSD_SRC_W-1:0] shutdown_source_enable;
	logic shutdown_status;
	logic auto_restart_enable;
	logic [1:0] bd_outputs_safe_state;
	logic [1:0] ac_outputs_safe_state;
	logic gen_enable;
	logic clk_source;
	logic [3:0] polarity;
	logic [`WSD_IRQ_W-1:0] irq_status;
	logic [`WSD_IRQ_W-1:0] irq_mask;
	logic auto_clear;
	logic shut_enter;
	wsd_hold_e hold_state;
	wsd_hold_e next_hold_state;
	logic forced;
	logic rise_band;
	logic fall_band;
	logic phase_ac;
	logic phase_bd;
	logic [1:0] next_a;
	logic [1:0] next_b;
	logic [1:0] next_c;
	logic [1:0] next_d;
	logic [`WSD_DATA_W-1:0] rd_mux;
	logic rd_hit;

	function automatic logic reg_hit(input logic [`WSD_ADDR_W-1:0] addr,
		input logic [13:0] idx);
		reg_hit = (addr[`WSD_ADDR_W-1:2] == idx);
	endfunction

	// Returns {enable, level} for one output pin.
	function automatic logic [1:0] drive(input logic raw, input logic pol,
		input logic [1:0] safe, input logic force_safe, input logic en);
		logic [1:0] res;
		res = 2'h0;
		if (force_safe) begin
			case (safe)
				WSD_SAFE_HIGH: res = 2'h3;
				WSD_SAFE_LOW: res = 2'h2;
				WSD_SAFE_TRI: res = 2'h0;
				WSD_SAFE_INACTIVE: res = {1'b1, pol};
				default: res = 2'h0;
			endcase
		end else if (en) begin
			res = {1'b1, raw ^ pol};
		end
		drive = res;
	endfunction

	// Comparator and pin inputs idle high, so they leave reset at one and
	// cannot fire a shutdown while the synchroniser fills.
	wsd_sync #(
		.WIDTH(NPIN),
		.INIT(PIN_INIT)
	) u_sync (
		.clk(CLK),
		.arst_n(ARST_N),
		.d({DATA_IN, COMPARATOR_TWO_OUTPUT, COMPARATOR_ONE_OUTPUT,
			TIMER_SIX_POSTSCALED, TIMER_FOUR_POSTSCALED, TIMER_TWO_POSTSCALED,
			SHUTDOWN_PIN}),
		.q(pin_q),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	assign data_lvl = pin_q[6];
	assign data_rise = pin_rise[6];
	assign data_fall = pin_fall[6];

	// Source activity, before enables.
	assign src_active[5] = ~pin_q[5]; // RULE8
	assign src_active[4] = ~pin_q[4]; // RULE8
	assign src_active[3] = pin_q[3]; // RULE9
	assign src_active[2] = pin_q[2]; // RULE9
	assign src_active[1] = pin_q[1]; // RULE9
	assign src_active[0] = ~pin_q[0]; // RULE10
	assign shut_req = |(src_active & shutdown_source_enable); // RULE7 RULE17

	// AXI4-Lite write side: address and data are taken independently.
	assign AWREADY = ~aw_held;
	assign WREADY = ~w_held;
	assign wr_fire = aw_held & w_held & ~BVALID;
	assign wr_lane0 = wr_fire & w_strb[0];

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end else if (AWVALID && !aw_held) begin
			aw_held <= 1'b1;
			aw_addr <= AWADDR;
		end else if (wr_fire) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= 4'h0;
		end else if (WVALID && !w_held) begin
			w_held <= 1'b1;
			w_data <= WDATA;
			w_strb <= WSTRB;
		end else if (wr_fire) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			BVALID <= 1'b0;
			BRESP <= `WSD_RESP_OKAY;
		end else if (wr_fire) begin
			BVALID <= 1'b1;
			BRESP <= rd_hit_w(aw_addr) ? `WSD_RESP_OKAY : `WSD_RESP_SLVERR;
		end else if (BREADY) begin
			BVALID <= 1'b0;
		end
	end

	function automatic logic rd_hit_w(input logic [`WSD_ADDR_W-1:0] a);
		rd_hit_w = reg_hit(a, `WSD_IDX_RISE_DB) | reg_hit(a, `WSD_IDX_FALL_DB)
			| reg_hit(a, `WSD_IDX_GEN_CTRL) | reg_hit(a, `WSD_IDX_POLARITY)
			| reg_hit(a, `WSD_IDX_SHUT_CTRL) | reg_hit(a, `WSD_IDX_SRC_EN)
			| reg_hit(a, `WSD_IDX_IRQ_STATUS) | reg_hit(a, `WSD_IDX_IRQ_MASK);
	endfunction

	// The counts carry no reset so a warm reset leaves them intact; only
	// power-up leaves them unknown.
	always_ff @(posedge CLK) begin
		if (wr_lane0 && reg_hit(aw_addr, `WSD_IDX_RISE_DB)) begin
			rise_deadband_count <= w_data[`WSD_DB_W-1:0]; // RULE14
		end
		if (wr_lane0 && reg_hit(aw_addr, `WSD_IDX_FALL_DB)) begin
			fall_deadband_count <= w_data[`WSD_DB_W-1:0]; // RULE14
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			shutdown_source_enable <= `WSD_SRC_EN_RST;
		end else if (wr_lane0 && reg_hit(aw_addr, `WSD_IDX_SRC_EN)) begin
			shutdown_source_enable <= w_data[`WSD_SRC_W-1:0]; // RULE7
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			gen_enable <= 1'b0;
			clk_source <= 1'b0;
			polarity <= `WSD_POL_RST;
		end else begin
			if (wr_lane0 && reg_hit(aw_addr, `WSD_IDX_GEN_CTRL)) begin
				gen_enable <= w_data[`WSD_BIT_ENABLE];
				clk_source <= w_data[`WSD_BIT_CLK_SRC]; // RULE16
			end
			if (wr_lane0 && reg_hit(aw_addr, `WSD_IDX_POLARITY)) begin
				polarity <= w_data[3:0];
			end
		end
	end

	assign GEN_CLK_SEL = clk_source; // RULE16

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			auto_restart_enable <= 1'b0;
			bd_outputs_safe_state <= `WSD_SAFE_RST;
			ac_outputs_safe_state <= `WSD_SAFE_RST;
		end else if (wr_lane0 && reg_hit(aw_addr, `WSD_IDX_SHUT_CTRL)) begin
			auto_restart_enable <= w_data[`WSD_BIT_REN]; // RULE2
			bd_outputs_safe_state <= w_data[5:4];
			ac_outputs_safe_state <= w_data[3:2];
		end
	end

	// A live source always wins over a software or automatic clear, so a
	// request that lands in the clearing cycle is never lost.
	assign auto_clear = shutdown_status & auto_restart_enable & ~shut_req; // RULE15
	assign shut_enter = ~shutdown_status & shut_req;

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			shutdown_status <= 1'b0;
		end else if (shut_req) begin
			shutdown_status <= 1'b1; // RULE17 RULE1
		end else if (wr_lane0 && reg_hit(aw_addr, `WSD_IDX_SHUT_CTRL)) begin
			// Setting by software is honoured only while the generator is off.
			shutdown_status <= w_data[`WSD_BIT_SHUTDOWN] & ~gen_enable; // RULE5 RULE2
		end else if (auto_clear) begin
			shutdown_status <= 1'b0; // RULE15
		end
	end

	// Safe drive outlives the status bit until the data input rises again.
	always_comb begin
		next_hold_state = hold_state;
		case (hold_state)
			WSD_RUN: begin
				if (shutdown_status) begin
					next_hold_state = WSD_SHUT;
				end
			end
			WSD_SHUT: begin
				if (!shutdown_status) begin
					next_hold_state = WSD_REARM;
				end
			end
			WSD_REARM: begin
				if (shutdown_status) begin
					next_hold_state = WSD_SHUT;
				end else if (data_rise) begin
					next_hold_state = WSD_RUN; // RULE6
				end
			end
			default: next_hold_state = WSD_RUN;
		endcase
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			hold_state <= WSD_RUN;
		end else begin
			hold_state <= next_hold_state;
		end
	end

	assign forced = shutdown_status | (hold_state != WSD_RUN); // RULE6 RULE5

	wsd_deadband #(
		.CW(`WSD_DB_W)
	) u_rise_band (
		.clk(CLK),
		.arst_n(ARST_N),
		.trig(data_rise),
		.count(rise_deadband_count),
		.active(rise_band)
	); // RULE11

	wsd_deadband #(
		.CW(`WSD_DB_W)
	) u_fall_band (
		.clk(CLK),
		.arst_n(ARST_N),
		.trig(data_fall),
		.count(fall_deadband_count),
		.active(fall_band)
	); // RULE12

	// Each phase turns on only once its own dead band has expired.
	assign phase_ac = data_lvl & ~rise_band; // RULE11
	assign phase_bd = ~data_lvl & ~fall_band; // RULE12

	assign next_a = drive(phase_ac, polarity[0], ac_outputs_safe_state, forced, gen_enable); // RULE4
	assign next_c = drive(phase_ac, polarity[2], ac_outputs_safe_state, forced, gen_enable); // RULE4
	assign next_b = drive(phase_bd, polarity[1], bd_outputs_safe_state, forced, gen_enable); // RULE3
	assign next_d = drive(phase_bd, polarity[3], bd_outputs_safe_state, forced, gen_enable); // RULE3

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			{OUT_A_OE, OUT_A} <= 2'h0;
			{OUT_B_OE, OUT_B} <= 2'h0;
			{OUT_C_OE, OUT_C} <= 2'h0;
			{OUT_D_OE, OUT_D} <= 2'h0;
		end else begin
			{OUT_A_OE, OUT_A} <= next_a;
			{OUT_B_OE, OUT_B} <= next_b;
			{OUT_C_OE, OUT_C} <= next_c;
			{OUT_D_OE, OUT_D} <= next_d;
		end
	end

	// Event flags are write-one-to-clear; a new event beats the clear.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			irq_status <= '0;
			irq_mask <= '0;
		end else begin
			if (wr_lane0 && reg_hit(aw_addr, `WSD_IDX_IRQ_MASK)) begin
				irq_mask <= w_data[`WSD_IRQ_W-1:0];
			end
			if (wr_lane0 && reg_hit(aw_addr, `WSD_IDX_IRQ_STATUS)) begin
				irq_status <= irq_status & ~w_data[`WSD_IRQ_W-1:0]
					| {auto_clear, shut_enter};
			end else begin
				irq_status <= irq_status | {auto_clear, shut_enter};
			end
		end
	end

	assign IRQ = |(irq_status & irq_mask);

	// Read side: one read in flight, answered the cycle after ARVALID.
	always_comb begin
		rd_mux = '0;
		rd_hit = 1'b1;
		if (reg_hit(ARADDR, `WSD_IDX_RISE_DB)) begin
			rd_mux[`WSD_DB_W-1:0] = rise_deadband_count;
		end else if (reg_hit(ARADDR, `WSD_IDX_FALL_DB)) begin
			rd_mux[`WSD_DB_W-1:0] = fall_deadband_count;
		end else if (reg_hit(ARADDR, `WSD_IDX_GEN_CTRL)) begin
			rd_mux[`WSD_BIT_ENABLE] = gen_enable;
			rd_mux[`WSD_BIT_CLK_SRC] = clk_source;
		end else if (reg_hit(ARADDR, `WSD_IDX_POLARITY)) begin
			rd_mux[`WSD_BIT_DATA_IN] = data_lvl;
			rd_mux[3:0] = polarity;
		end else if (reg_hit(ARADDR, `WSD_IDX_SHUT_CTRL)) begin
			rd_mux[`WSD_BIT_SHUTDOWN] = shutdown_status; // RULE1
			rd_mux[`WSD_BIT_REN] = auto_restart_enable;
			rd_mux[5:4] = bd_outputs_safe_state;
			rd_mux[3:2] = ac_outputs_safe_state;
		end else if (reg_hit(ARADDR, `WSD_IDX_SRC_EN)) begin
			rd_mux[`WSD_SRC_W-1:0] = shutdown_source_enable;
		end else if (reg_hit(ARADDR, `WSD_IDX_IRQ_STATUS)) begin
			rd_mux[`WSD_IRQ_W-1:0] = irq_status;
		end else if (reg_hit(ARADDR, `WSD_IDX_IRQ_MASK)) begin
			rd_mux[`WSD_IRQ_W-1:0] = irq_mask;
		end else begin
			rd_hit = 1'b0;
		end
	end

	assign ARREADY = ~RVALID;

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			RVALID <= 1'b0;
			RDATA <= '0;
			RRESP <= `WSD_RESP_OKAY;
		end else if (ARVALID && !RVALID) begin
			RVALID <= 1'b1;
			RDATA <= rd_mux;
			RRESP <= rd_hit ? `WSD_RESP_OKAY : `WSD_RESP_SLVERR;
		end else if (RREADY) begin
			RVALID <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* wsd_far.sv */
// Purpose: Model of the shutdown sources that face wsd_top.
// Assumes: Bit k of trip set means source k is in its fault condition.
// Notes:   Levels only; the real sources carry no clock of their own.
`timescale 1ns/1ps
`default_nettype none
module wsd_far (
	input wire logic [5:0] trip,
	output logic comp_two,
	output logic comp_one,
	output logic timer_six,
	output logic timer_four,
	output logic timer_two,
	output logic pin
);
	// Comparators and the pin pull low to ask for shutdown, timers drive high.
	assign comp_two = ~trip[5];
	assign comp_one = ~trip[4];
	assign timer_six = trip[3];
	assign timer_four = trip[2];
	assign timer_two = trip[1];
	assign pin = ~trip[0];
endmodule
`default_nettype wire

/* wsd_top_properties.sv */
// Purpose: Port-level assertions for wsd_top.
// Assumes: One clock domain, reset active low.
// Notes:   Attached to every wsd_top by the bind below.
`timescale 1ns/1ps
`default_nettype none
module wsd_top_properties (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic AWVALID,
	input wire logic AWREADY,
	input wire logic WVALID,
	input wire logic WREADY,
	input wire logic [1:0] BRESP,
	input wire logic BVALID,
	input wire logic BREADY,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic [31:0] RDATA,
	input wire logic RVALID,
	input wire logic RREADY,
	input wire logic OUT_A_OE,
	input wire logic OUT_B_OE,
	input wire logic OUT_C_OE,
	input wire logic OUT_D_OE
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!ARST_N);
	a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY && !BVALID |=> ##1 BVALID)
		else $error("write response late");
	a_bresp_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("write response dropped early");
	a_bresp_done: assert property (BVALID && BREADY |=> !BVALID)
		else $error("write response not withdrawn");
	a_ar_refused: assert property (RVALID |-> !ARREADY)
		else $error("read address accepted while answering");
	a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
		else $error("read answer late");
	a_rdata_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
		else $error("read data changed while held");
	a_rdata_done: assert property (RVALID && RREADY |=> !RVALID)
		else $error("read answer not withdrawn");
	a_oe_pair_ac: assert property (OUT_A_OE == OUT_C_OE)
		else $error("outputs A and C disagree on drive");
	a_oe_pair_bd: assert property (OUT_B_OE == OUT_D_OE)
		else $error("outputs B and D disagree on drive");
endmodule
bind wsd_top wsd_top_properties i_wsd_top_properties (.CLK, .ARST_N, .AWVALID, .AWREADY,
	.WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARVALID, .ARREADY, .RDATA, .RVALID, .RREADY,
	.OUT_A_OE, .OUT_B_OE, .OUT_C_OE, .OUT_D_OE);
`default_nettype wire

/* tb.sv */
// Purpose: Self-checking bench for wsd_top.
// Assumes: Pins pass the synchroniser within eight clocks.
// Notes:   Reads queue their expected word; a monitor compares on completion.
`timescale 1ns/1ps
`default_nettype none
`include "wsd_defs.svh"
module tb;
	logic CLK = 1'b0;
	logic ARST_N = 1'b0;
	logic [15:0] AWADDR = 16'h0000;
	logic [15:0] ARADDR = 16'h0000;
	logic [31:0] WDATA = 32'h00000000;
	logic AWVALID = 1'b0, WVALID = 1'b0, ARVALID = 1'b0, DATA_IN = 1'b0;
	// Ready idles high; a lag holds it low for a few cycles so the slave must wait.
	logic BREADY = 1'b1, RREADY = 1'b1;
	logic [5:0] trip = 6'h00;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, GEN_CLK_SEL, IRQ;
	logic [1:0] BRESP, RRESP;
	logic [31:0] RDATA;
	wire logic [3:0] o, oe;
	wire logic c2, c1, t6, t4, t2, sp;
	logic [5:0] nr, nf;
	logic [1:0] bd, ac;
	int miscompares = 0;
	int num_checks = 0;
	int g, r;
	logic [33:0] expq[$];
	initial begin
		forever #10 CLK = ~CLK;
	end
	wsd_far i_wsd_far (.trip, .comp_two(c2), .comp_one(c1), .timer_six(t6), .timer_four(t4),
		.timer_two(t2), .pin(sp));
	wsd_top i_wsd_top (.CLK, .ARST_N, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB(4'hf),
		.WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA,
		.RRESP, .RVALID, .RREADY, .DATA_IN, .COMPARATOR_TWO_OUTPUT(c2),
		.COMPARATOR_ONE_OUTPUT(c1), .TIMER_SIX_POSTSCALED(t6), .TIMER_FOUR_POSTSCALED(t4),
		.TIMER_TWO_POSTSCALED(t2), .SHUTDOWN_PIN(sp), .OUT_A(o[0]), .OUT_A_OE(oe[0]),
		.OUT_B(o[1]), .OUT_B_OE(oe[1]), .OUT_C(o[2]), .OUT_C_OE(oe[2]), .OUT_D(o[3]),
		.OUT_D_OE(oe[3]), .GEN_CLK_SEL, .IRQ);
	task automatic check(input string nm, input logic [33:0] e, input logic [33:0] s);
		num_checks++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Ready flags are sampled at the falling edge so no edge race decides them.
	task automatic wr(input logic [13:0] ix, input logic [7:0] d, input logic [1:0] er = 2'h0,
		input int lag = 0);
		logic aw, w, b;
		logic [1:0] bs;
		AWADDR <= {ix, 2'b00};
		WDATA <= {24'h000000, d};
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		if (lag > 0) BREADY <= 1'b0;
		do begin
			@(negedge CLK);
			aw = AWREADY & AWVALID;
			w = WREADY & WVALID;
			b = BVALID & BREADY;
			bs = BRESP;
			@(posedge CLK);
			if (aw) AWVALID <= 1'b0;
			if (w) WVALID <= 1'b0;
			if (lag == 1) BREADY <= 1'b1;
			if (lag > 0) lag--;
		end while (!b);
		check("write response", {32'h0, er}, {32'h0, bs});
	endtask
	task automatic rd(input logic [13:0] ix, input logic [7:0] ed, input logic [1:0] er = 2'h0,
		input int lag = 0);
		logic a, rv;
		expq.push_back({er, 24'h000000, ed});
		ARADDR <= {ix, 2'b00};
		ARVALID <= 1'b1;
		if (lag > 0) RREADY <= 1'b0;
		do begin
			@(negedge CLK);
			a = ARREADY & ARVALID;
			rv = RVALID & RREADY;
			@(posedge CLK);
			if (a) ARVALID <= 1'b0;
			if (lag == 1) RREADY <= 1'b1;
			if (lag > 0) lag--;
		end while (!rv);
	endtask
	always @(negedge CLK) begin
		if (RVALID === 1'b1 && RREADY === 1'b1) begin
			check("read word", expq.pop_front(), {RRESP, RDATA});
		end
	end
	function automatic logic [7:0] safe(input logic [1:0] b, input logic [1:0] a,
		input logic [3:0] p);
		logic [3:0] e, v;
		logic [1:0] c;
		for (int k = 0; k < 4; k++) begin
			c = k[0] ? b : a;
			e[k] = c != 2'h1;
			v[k] = c == 2'h3 || (c == 2'h0 && p[k]);
		end
		return {e, v};
	endfunction
	task automatic outs(input logic [7:0] e);
		@(negedge CLK);
		check("outputs", {26'h0, e}, {26'h0, oe, o & oe});
		@(posedge CLK);
	endtask
	// Counts clocks with both phases low after a data edge.
	task automatic band(input logic v, output int n);
		DATA_IN <= v;
		n = 0;
		repeat (90) begin
			@(negedge CLK);
			if (o[!v] === 1'b0 && o[v] === 1'b0) n++;
		end
		@(posedge CLK);
	endtask
	initial begin
		repeat (20000) @(posedge CLK);
		miscompares++;
		$display("watchdog expired");
		tally_and_finish();
	end
	initial begin
		void'($urandom(32'h008f0342));
		repeat (12) @(posedge CLK);
		ARST_N <= 1'b1;
		@(posedge CLK);
		rd(`WSD_IDX_SHUT_CTRL, 8'h14);
		rd(`WSD_IDX_SRC_EN, 8'h00, 2'h0, 3);
		wr(14'h0f40, 8'hff, `WSD_RESP_SLVERR);
		rd(14'h0f40, 8'h00, `WSD_RESP_SLVERR);
		$display("test reset values done");
		nr = 6'($urandom);
		wr(`WSD_IDX_RISE_DB, {2'h0, nr});
		wr(`WSD_IDX_FALL_DB, 8'h3f, 2'h0, 3);
		ARST_N <= 1'b0;
		repeat (2) @(posedge CLK);
		ARST_N <= 1'b1;
		@(posedge CLK);
		rd(`WSD_IDX_RISE_DB, {2'h0, nr});
		rd(`WSD_IDX_FALL_DB, 8'h3f);
		$display("test count retention done");
		wr(`WSD_IDX_GEN_CTRL, 8'h81);
		outs(8'hfa);
		check("clock select", 34'h1, {33'h0, GEN_CLK_SEL});
		for (int k = 0; k < 3; k++) begin
			nr = k == 0 ? 6'h00 : k == 1 ? 6'($urandom) : 6'h3f;
			nf = ~nr;
			wr(`WSD_IDX_RISE_DB, {2'h0, nr});
			wr(`WSD_IDX_FALL_DB, {2'h0, nf});
			band(1'b1, g);
			check("rise band", 34'h1, {33'h0, g >= nr && g <= nr + 1});
			band(1'b0, g);
			check("fall band", 34'h1, {33'h0, g >= nf && g <= nf + 1});
		end
		wr(`WSD_IDX_RISE_DB, 8'h00);
		wr(`WSD_IDX_FALL_DB, 8'h00);
		$display("test dead band done");
		for (int i = 0; i < 6; i++) begin
			bd = 2'(i);
			ac = 2'(3 - i);
			wr(`WSD_IDX_IRQ_MASK, 8'(i % 2));
			wr(`WSD_IDX_SHUT_CTRL, {2'h0, bd, ac, 2'h0});
			wr(`WSD_IDX_SRC_EN, 8'h3f ^ 8'(1 << i));
			trip <= 6'(1 << i);
			repeat (8) @(posedge CLK);
			rd(`WSD_IDX_SHUT_CTRL, {2'h0, bd, ac, 2'h0});
			wr(`WSD_IDX_SRC_EN, 8'(1 << i));
			repeat (8) @(posedge CLK);
			rd(`WSD_IDX_SHUT_CTRL, {2'h2, bd, ac, 2'h0});
			outs(safe(bd, ac, 4'h0));
			check("irq", 34'(i % 2), {33'h0, IRQ});
			trip <= 6'h00;
			repeat (8) @(posedge CLK);
			wr(`WSD_IDX_IRQ_STATUS, 8'h01);
			check("irq clear", 34'h0, {33'h0, IRQ});
			rd(`WSD_IDX_SHUT_CTRL, {2'h2, bd, ac, 2'h0});
			wr(`WSD_IDX_SHUT_CTRL, {2'h0, bd, ac, 2'h0});
			repeat (8) @(posedge CLK);
			outs(safe(bd, ac, 4'h0));
			DATA_IN <= 1'b1;
			repeat (8) @(posedge CLK);
			outs(8'hf5);
			DATA_IN <= 1'b0;
			repeat (8) @(posedge CLK);
		end
		$display("test shutdown sources done");
		r = $urandom_range(5);
		wr(`WSD_IDX_SHUT_CTRL, 8'h40);
		wr(`WSD_IDX_SRC_EN, 8'(1 << r));
		trip <= 6'(1 << r);
		repeat (8) @(posedge CLK);
		rd(`WSD_IDX_SHUT_CTRL, 8'hc0);
		trip <= 6'h00;
		repeat (8) @(posedge CLK);
		rd(`WSD_IDX_SHUT_CTRL, 8'h40);
		rd(`WSD_IDX_IRQ_STATUS, 8'h03);
		outs(8'hf0);
		DATA_IN <= 1'b1;
		repeat (8) @(posedge CLK);
		DATA_IN <= 1'b0;
		$display("test auto restart done");
		wr(`WSD_IDX_GEN_CTRL, 8'h00);
		outs(8'h00);
		check("clock select", 34'h0, {33'h0, GEN_CLK_SEL});
		wr(`WSD_IDX_POLARITY, 8'h05);
		wr(`WSD_IDX_SHUT_CTRL, 8'h80);
		outs(safe(2'h0, 2'h0, 4'h5));
		rd(`WSD_IDX_SHUT_CTRL, 8'h80);
		$display("test software shutdown done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
